// [core/bem_pkg.sv]
// Functional notes
// [RULE1] Event 60H adds pending line reads per cycle.
// [RULE2] Read pending from issue until line received.
// [RULE3] Pending reads: L1D or L2 prefetch line reads.
// [RULE4] Pending excludes ownership reads, fetches, others.
// [RULE5] Event 61H counts each own stall assertion.
// [RULE6] Stall asserts when outstanding nears bus maximum.
// [RULE7] Each stall assertion lasts exactly two cycles.
// [RULE8] No new transaction issued while stall asserted.
// [RULE9] Event 62H counts data-valid bus cycles.
// [RULE10] Own agent: count only own data drives.
// [RULE11] Any agent: count every data-valid cycle.
// [RULE12] Event 63H counts cycles with lock asserted.
// [RULE13] Lock for uncacheable, split, uncacheable walk.
// [RULE14] Software should avoid bus locks entirely.
// [RULE15] Event 64H counts cycles receiving data.
// [RULE16] Event 65H counts qualifying burst read issues.
// [RULE17] Burst reads exclude ownership reads.
// [RULE18] Qualifiers accepted per event as listed.
// [RULE19] Selected event increments; unsupported codes add nothing.
package bem_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // Control field positions.
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_CORE_ALL = 8;
  localparam int CTRL_AGENT_ALL = 9;
  localparam int CTRL_ENABLE = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  // Supported event codes.
  localparam logic [7:0] EV_PEND_READ = 8'h60;
  localparam logic [7:0] EV_STALL_DRV = 8'h61;
  localparam logic [7:0] EV_DATA_VALID = 8'h62;
  localparam logic [7:0] EV_LOCK = 8'h63;
  localparam logic [7:0] EV_RCV_BUSY = 8'h64;
  localparam logic [7:0] EV_BURST_RD = 8'h65;
  // Transaction kinds and requesting sources.
  localparam logic [1:0] KIND_LINE_RD = 2'h0;
  localparam logic [1:0] KIND_OWN_RD = 2'h1;
  localparam logic [1:0] KIND_IFETCH = 2'h2;
  localparam logic [1:0] KIND_OTHER = 2'h3;
  localparam logic [1:0] SRC_L1D = 2'h0;
  localparam logic [1:0] SRC_L2PF = 2'h1;
  localparam logic [1:0] SRC_IFU = 2'h2;
  // Outstanding transaction level that triggers a stall.
  localparam logic [4:0] STALL_THRESH = 5'h0e;
  // Bus cycles per stall assertion.
  localparam int STALL_CYCLES = 2;
  localparam int TAG_W = 3;
  localparam int PEND_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD1 = 3'b010,
    ST_HOLD2 = 3'b100
  } bem_stall_e;
endpackage : bem_pkg

// [core/bem_pend_track.sv]
`timescale 1ns/1ps
`default_nettype none
module bem_pend_track (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic issueTake,
  input wire logic [bem_pkg::TAG_W-1:0] issueTag,
  input wire logic issueQual,
  input wire logic issueByCore,
  input wire logic doneValid,
  input wire logic [bem_pkg::TAG_W-1:0] doneTag,
  output logic [bem_pkg::PEND_W-1:0] pendCore,
  output logic [bem_pkg::PEND_W-1:0] pendAll
);
  localparam int DEPTH = 1 << bem_pkg::TAG_W;
  localparam int PEND_W = bem_pkg::PEND_W;
  logic [DEPTH-1:0] qualMem;
  logic [DEPTH-1:0] coreMem;
  logic addAll;
  logic addCore;
  logic subAll;
  logic subCore;

  // A tag remembers whether its read is tracked until the line is in.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qualMem <= '0;
      coreMem <= '0;
    end else begin
      if (doneValid) begin
        qualMem[doneTag] <= 1'b0; // RULE2
      end
      if (issueTake) begin
        qualMem[issueTag] <= issueQual; // RULE3
        coreMem[issueTag] <= issueByCore;
      end
    end
  end

  // Count changes from issue and completion of tracked reads.
  assign addAll = issueTake & issueQual;
  assign addCore = addAll & issueByCore;
  assign subAll = doneValid & qualMem[doneTag];
  assign subCore = subAll & coreMem[doneTag];

  // Pending totals for this core and for all cores.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pendAll <= '0;
      pendCore <= '0;
    end else begin
      pendAll <= pendAll + PEND_W'(addAll) - PEND_W'(subAll); // RULE2
      pendCore <= pendCore + PEND_W'(addCore) - PEND_W'(subCore);
    end
  end
endmodule : bem_pend_track
`default_nettype wire

// [core/bem_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bem_top (
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite slave.
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Read transactions issued and completed by this processor, and burst reads of other agents.
  input wire logic issueValid,
  input wire logic [bem_pkg::TAG_W-1:0] issueTag,
  input wire logic [1:0] issueKind,
  input wire logic [1:0] issueSrc,
  input wire logic issueCacheable,
  input wire logic issueByCore,
  input wire logic doneValid,
  input wire logic [bem_pkg::TAG_W-1:0] doneTag,
  input wire logic extBurstRd,
  // Stall generation and observation.
  input wire logic [4:0] txnOutstanding,
  input wire logic extStallRise,
  // Data-valid, lock and receive activity.
  input wire logic ownDataDrive,
  input wire logic anyDataValid,
  input wire logic lockUncached,
  input wire logic lockSplit,
  input wire logic lockWalkUc,
  input wire logic lockByCore,
  input wire logic extLock,
  input wire logic rcvBusy,
  input wire logic rcvByCore,
  // Driven bus signals.
  output logic busStall,
  output logic issueOk,
  output logic busLock
);
  logic [31:0] ctrl;
  logic [31:0] count;
  logic [7:0] evCode;
  logic coreAll;
  logic agentAll;
  logic enable;
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic wrStb;
  logic cntWr;
  logic [31:0] rdMux;
  logic rdHit;
  bem_pkg::bem_stall_e stState;
  bem_pkg::bem_stall_e next_stState;
  logic stallRise;
  logic issueTake;
  logic pendQual;
  logic burstQual;
  logic [bem_pkg::PEND_W-1:0] pendCore;
  logic [bem_pkg::PEND_W-1:0] pendAll;
  logic [bem_pkg::PEND_W-1:0] inc;
  logic ownLockReq;
  localparam int PEND_W = bem_pkg::PEND_W;

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // Passes an activity when it matches the core and agent selection.
  function automatic logic qualOk(input logic selCoreAll, input logic selAgentAll,
                                  input logic byCore, input logic byAgent);
    return (selCoreAll | byCore) & (selAgentAll | byAgent);
  endfunction : qualOk

  assign evCode = ctrl[bem_pkg::CTRL_CODE_LSB +: 8];
  assign coreAll = ctrl[bem_pkg::CTRL_CORE_ALL];
  assign agentAll = ctrl[bem_pkg::CTRL_AGENT_ALL];
  assign enable = ctrl[bem_pkg::CTRL_ENABLE];

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  // Address and data are caught in either order; the response follows both.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= bem_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wready <= 1'b0;
      end
      if (wrStb) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddrQ == bem_pkg::OFS_CTRL || awAddrQ == bem_pkg::OFS_COUNT ||
                  awAddrQ == bem_pkg::OFS_STATUS) ? bem_pkg::RESP_OKAY
                                                  : bem_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  assign wrStb = awHeld & wHeld & ~bvalid;
  assign cntWr = wrStb & (awAddrQ == bem_pkg::OFS_COUNT);

  // Control register; status is read-only and ignores writes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= bem_pkg::CTRL_RESET;
    end else if (wrStb && awAddrQ == bem_pkg::OFS_CTRL) begin
      ctrl <= mergeBytes(ctrl, wDataQ, wStrbQ) & 32'h0000_07ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  // Read data mux; unmapped offsets read zero with an error response.
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    case (araddr)
      bem_pkg::OFS_CTRL: rdMux = ctrl;
      bem_pkg::OFS_COUNT: rdMux = count;
      bem_pkg::OFS_STATUS: rdMux = {22'h0, busLock, busStall, pendCore, pendAll};
      default: rdHit = 1'b0;
    endcase
  end

  // One read at a time, answered the cycle after the address is taken.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= bem_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdHit ? bem_pkg::RESP_OKAY : bem_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus stall generation.

  // A stall lasts two cycles and starts when the bus is nearly full.
  always_comb begin
    next_stState = stState;
    unique case (stState)
      bem_pkg::ST_IDLE: begin
        if (txnOutstanding >= bem_pkg::STALL_THRESH) begin
          next_stState = bem_pkg::ST_HOLD1; // RULE6
        end
      end
      bem_pkg::ST_HOLD1: next_stState = bem_pkg::ST_HOLD2; // RULE7
      bem_pkg::ST_HOLD2: next_stState = bem_pkg::ST_IDLE;
      default: next_stState = bem_pkg::ST_IDLE;
    endcase
  end

  // State, stall output and issue permission share one next value.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stState <= bem_pkg::ST_IDLE;
      busStall <= 1'b0;
      issueOk <= 1'b1;
    end else begin
      stState <= next_stState;
      busStall <= (next_stState != bem_pkg::ST_IDLE); // RULE7
      issueOk <= (next_stState == bem_pkg::ST_IDLE); // RULE8
    end
  end

  assign stallRise = busStall & (stState == bem_pkg::ST_HOLD1); // RULE5

  //////////////////////////////////////////////////////////////////////////
  // Transaction classification and lock drive.

  // Only permitted issues are taken; a request during a stall is dropped.
  assign issueTake = issueValid & issueOk; // RULE8
  // Cacheable line reads from the data cache or level-two prefetch only.
  assign pendQual = issueKind == bem_pkg::KIND_LINE_RD && issueCacheable &&
                    (issueSrc == bem_pkg::SRC_L1D || issueSrc == bem_pkg::SRC_L2PF); // RULE3 RULE4
  // Burst reads add cacheable instruction fetch misses, never ownership reads.
  assign burstQual = pendQual || (issueKind == bem_pkg::KIND_IFETCH && issueCacheable &&
                     issueSrc == bem_pkg::SRC_IFU); // RULE16 RULE17

  bem_pend_track u_pend (
    .sys_clk(sys_clk),
    .rst(rst),
    .issueTake(issueTake),
    .issueTag(issueTag),
    .issueQual(pendQual),
    .issueByCore(issueByCore),
    .doneValid(doneValid),
    .doneTag(doneTag),
    .pendCore(pendCore),
    .pendAll(pendAll)
  );

  assign ownLockReq = lockUncached | lockSplit | lockWalkUc;

  // The lock line is held for locked uncacheable, split and walk accesses.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busLock <= 1'b0;
    end else begin
      busLock <= ownLockReq; // RULE13
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event selection and counter.

  // Per-cycle increment of the selected event with its qualifiers.
  always_comb begin
    inc = '0;
    case (evCode) // RULE19
      bem_pkg::EV_PEND_READ: begin
        // A read counts in its issue cycle and until its line is in.
        inc = (coreAll ? pendAll : pendCore) +
              PEND_W'(issueTake & pendQual & (coreAll | issueByCore)); // RULE1 RULE2
      end
      bem_pkg::EV_STALL_DRV: begin
        inc = PEND_W'(stallRise | (agentAll & extStallRise)); // RULE5 RULE18
      end
      bem_pkg::EV_DATA_VALID: begin
        inc = PEND_W'(agentAll ? anyDataValid : ownDataDrive); // RULE9 RULE10 RULE11
      end
      bem_pkg::EV_LOCK: begin
        inc = PEND_W'((busLock & qualOk(coreAll, agentAll, lockByCore, 1'b1)) |
                      (extLock & agentAll)); // RULE12 RULE18
      end
      bem_pkg::EV_RCV_BUSY: begin
        inc = PEND_W'(rcvBusy & (coreAll | rcvByCore)); // RULE15 RULE18
      end
      bem_pkg::EV_BURST_RD: begin
        inc = PEND_W'(issueTake & burstQual &
                      qualOk(coreAll, agentAll, issueByCore, 1'b1)) +
              PEND_W'(extBurstRd & agentAll); // RULE16 RULE18
      end
      default: inc = '0;
    endcase
  end

  // A software write to the counter wins over that cycle's increment.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= bem_pkg::COUNT_RESET;
    end else if (cntWr) begin
      count <= mergeBytes(count, wDataQ, wStrbQ);
    end else if (enable) begin
      count <= count + 32'(inc); // RULE19
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_stall_two;
    $rose(busStall) |-> busStall ##1 busStall ##1 !busStall;
  endproperty
  a_stall_two: assert property (p_stall_two) else $error("stall not two cycles"); // RULE7

  property p_stall_start;
    (stState == bem_pkg::ST_IDLE && txnOutstanding >= bem_pkg::STALL_THRESH) |=> busStall;
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("stall missed"); // RULE6

  property p_no_issue;
    busStall |-> !issueOk && !issueTake;
  endproperty
  a_no_issue: assert property (p_no_issue) else $error("issue during stall"); // RULE8

  property p_stall_cnt;
    (enable && !cntWr && evCode == bem_pkg::EV_STALL_DRV && !agentAll && $rose(busStall))
      |=> count == $past(count) + 32'h1;
  endproperty
  a_stall_cnt: assert property (p_stall_cnt) else $error("stall not counted"); // RULE5

  property p_dv_any;
    (enable && !cntWr && evCode == bem_pkg::EV_DATA_VALID && agentAll && anyDataValid)
      |=> count == $past(count) + 32'h1;
  endproperty
  a_dv_any: assert property (p_dv_any) else $error("data valid missed"); // RULE11

  property p_lock_drv;
    ownLockReq |=> busLock;
  endproperty
  a_lock_drv: assert property (p_lock_drv) else $error("lock not driven"); // RULE13

  property p_rcv_core;
    (evCode == bem_pkg::EV_RCV_BUSY && !coreAll && !rcvByCore && !cntWr) |=> $stable(count);
  endproperty
  a_rcv_core: assert property (p_rcv_core) else $error("foreign core counted"); // RULE18

  property p_unsup;
    (!cntWr && (evCode < bem_pkg::EV_PEND_READ || evCode > bem_pkg::EV_BURST_RD))
      |=> $stable(count);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code counted"); // RULE19

  property p_pend_add;
    (enable && !cntWr && evCode == bem_pkg::EV_PEND_READ && coreAll && !issueValid)
      |=> count == $past(count) + 32'($past(pendAll));
  endproperty
  a_pend_add: assert property (p_pend_add) else $error("pending sum wrong"); // RULE1

  property p_rfo_excl;
    (issueValid && issueKind == bem_pkg::KIND_OWN_RD) |-> !pendQual && !burstQual;
  endproperty
  a_rfo_excl: assert property (p_rfo_excl) else $error("ownership read counted"); // RULE17
endmodule : bem_top
`default_nettype wire

// [bench/bem_agent_model.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Other bus agents: bus load, foreign data, lock, stall and burst traffic.
module bem_agent_model (
  input wire logic sys_clk,
  input wire logic busStall,
  input wire logic ownDataDrive,
  output logic [4:0] txnOutstanding,
  output logic anyDataValid,
  output logic extLock,
  output logic extStallRise,
  output logic extBurstRd
);
  logic [3:0] act;
  // The data line is shared, so it shows the data cycles of every agent.
  assign anyDataValid = act[0] | ownDataDrive;
  assign extLock = act[1];
  assign extStallRise = act[2];
  assign extBurstRd = act[3];
  // Nothing is active until a scenario asks for it.
  initial begin
    act = 4'h0;
    txnOutstanding = 5'h00;
  end
  // Drives one activity for n cycles; with gap each pulse is one cycle long.
  task automatic drive(input int sel, input int n, input bit gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      while (sel == 3 && busStall) @(posedge sys_clk);
      act[sel] <= 1'b1;
      if (gap) begin
        @(posedge sys_clk);
        act[sel] <= 1'b0;
      end
    end
    @(posedge sys_clk);
    act[sel] <= 1'b0;
  endtask : drive
  // Sets how many data and snoop transactions stand open on the bus.
  task automatic load(input logic [4:0] lvl);
    @(posedge sys_clk);
    txnOutstanding <= lvl;
  endtask : load
endmodule : bem_agent_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, issueValid, issueCacheable, doneValid;
  logic ownDataDrive, lockUncached, lockSplit, lockWalkUc, rcvBusy;
  logic lockByCore, rcvByCore;
  logic extStallRise, anyDataValid, extLock, extBurstRd, busStall, issueOk, busLock;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, issueKind, issueSrc;
  logic [bem_pkg::TAG_W-1:0] issueTag, doneTag;
  logic [4:0] txnOutstanding;
  int badCount, checks;
  bem_top uut (
    .sys_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .issueValid, .issueTag, .issueKind, .issueSrc, .issueCacheable, .issueByCore(1'b1),
    .doneValid, .doneTag, .extBurstRd, .txnOutstanding, .extStallRise, .ownDataDrive,
    .anyDataValid, .lockUncached, .lockSplit, .lockWalkUc, .lockByCore, .extLock,
    .rcvBusy, .rcvByCore, .busStall, .issueOk, .busLock
  );
  bem_agent_model agent (
    .sys_clk, .busStall, .ownDataDrive, .txnOutstanding, .anyDataValid, .extLock,
    .extStallRise, .extBurstRd
  );
  //////////////////////////////////////////////////////////////////////////////
  // Free-running 40 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (badCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // Register write; address and data are released as each is taken.
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite
  // Register read; the answer is taken at the edge that sees rvalid.
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead
  // Selects an event and clears the count.
  task automatic setup(input logic [31:0] ctrl);
    logic [1:0] r;
    axiWrite(bem_pkg::OFS_CTRL, ctrl, r);
    axiWrite(bem_pkg::OFS_COUNT, 32'h0, r);
  endtask : setup
  // Reads the count and compares it.
  task automatic expectCount(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(bem_pkg::OFS_COUNT, d, r);
    check(d, exp);
  endtask : expectCount
  // Issues one read on the bus; it stays valid until the next issue, done or quiet call.
  task automatic issue(input int t, input logic [1:0] k, input logic [1:0] s, input logic c);
    @(posedge sys_clk);
    issueValid <= 1'b1;
    issueTag <= 3'(t);
    issueKind <= k;
    issueSrc <= s;
    issueCacheable <= c;
  endtask : issue
  // Reports the whole line of one tag received.
  task automatic done(input int t);
    @(posedge sys_clk);
    issueValid <= 1'b0;
    doneValid <= 1'b1;
    doneTag <= 3'(t);
  endtask : done
  // Returns the transaction inputs to rest.
  task automatic quiet();
    @(posedge sys_clk);
    issueValid <= 1'b0;
    doneValid <= 1'b0;
  endtask : quiet
  // Three own data cycles, then two of another agent.
  task automatic dataRun();
    @(posedge sys_clk);
    ownDataDrive <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(posedge sys_clk);
    ownDataDrive <= 1'b0;
    agent.drive(0, 2, 0);
  endtask : dataRun
  //////////////////////////////////////////////////////////////////////////////
  // Register map, reset values and refused accesses.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axiRead(bem_pkg::OFS_CTRL, d, r);
    check(d, bem_pkg::CTRL_RESET);
    axiRead(bem_pkg::OFS_COUNT, d, r);
    check(d, bem_pkg::COUNT_RESET);
    axiRead(4'hc, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, bem_pkg::RESP_SLVERR});
    axiWrite(4'hc, 32'h1, r);
    check(r, bem_pkg::RESP_SLVERR);
    axiWrite(bem_pkg::OFS_STATUS, 32'hffff_ffff, r);
    check(r, bem_pkg::RESP_OKAY);
    axiRead(bem_pkg::OFS_STATUS, d, r);
    check(d, 32'h0);
    axiWrite(bem_pkg::OFS_CTRL, 32'hffff_ffff, r);
    axiRead(bem_pkg::OFS_CTRL, d, r);
    check(d, 32'h0000_07ff);
  endtask : t_regs
  // Pending line reads summed per cycle; other kinds add nothing.
  task automatic t_pend();
    setup(32'h560);
    issue(1, bem_pkg::KIND_LINE_RD, bem_pkg::SRC_L1D, 1'b1);
    issue(2, bem_pkg::KIND_LINE_RD, bem_pkg::SRC_L2PF, 1'b1);
    done(1);
    done(2);
    quiet();
    expectCount(6);
    issue(3, bem_pkg::KIND_OWN_RD, bem_pkg::SRC_L1D, 1'b1);
    issue(4, bem_pkg::KIND_IFETCH, bem_pkg::SRC_IFU, 1'b1);
    issue(5, bem_pkg::KIND_OTHER, bem_pkg::SRC_L1D, 1'b1);
    issue(6, bem_pkg::KIND_LINE_RD, bem_pkg::SRC_L1D, 1'b0);
    for (int t = 3; t < 7; t++) done(t);
    quiet();
    expectCount(6);
  endtask : t_pend
  // Own stall assertions: two cycles each, one count each, issues held off.
  task automatic t_stall();
    int high;
    int rises;
    logic prev;
    high = 0;
    rises = 0;
    prev = 1'b0;
    setup(32'h461);
    agent.load(5'h0e);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) agent.load(5'h00);
      else @(posedge sys_clk);
      high += int'(busStall);
      rises += int'(busStall && !prev);
      prev = busStall;
      check({31'h0, issueOk}, {31'h0, !busStall});
    end
    check(32'(rises != 0), 32'h1);
    check(32'(high), 32'(2 * rises));
    expectCount(32'(rises));
    setup(32'h661);
    agent.drive(2, 2, 1);
    expectCount(2);
  endtask : t_stall
  // Data-valid cycles with each agent qualifier, and an unsupported code.
  task automatic t_data();
    setup(32'h462);
    dataRun();
    expectCount(3);
    setup(32'h662);
    dataRun();
    expectCount(5);
    setup(32'h466);
    dataRun();
    expectCount(0);
  endtask : t_data
  // Brief lock cycles from each cause, another core's, then another agent's lock.
  task automatic t_lock();
    setup(32'h563);
    @(posedge sys_clk);
    lockUncached <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    lockUncached <= 1'b0;
    lockSplit <= 1'b1;
    @(posedge sys_clk);
    lockSplit <= 1'b0;
    lockWalkUc <= 1'b1;
    @(posedge sys_clk);
    lockWalkUc <= 1'b0;
    expectCount(4);
    setup(32'h463);
    @(posedge sys_clk);
    lockByCore <= 1'b0;
    lockSplit <= 1'b1;
    @(posedge sys_clk);
    lockSplit <= 1'b0;
    repeat (2) @(posedge sys_clk);
    lockByCore <= 1'b1;
    expectCount(0);
    setup(32'h763);
    agent.drive(1, 3, 0);
    expectCount(3);
  endtask : t_lock
  // Receive-busy cycles, then burst reads of own and other agents.
  task automatic t_rcvBurst();
    setup(32'h564);
    @(posedge sys_clk);
    rcvBusy <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(posedge sys_clk);
    rcvBusy <= 1'b0;
    expectCount(5);
    setup(32'h464);
    @(posedge sys_clk);
    rcvByCore <= 1'b0;
    rcvBusy <= 1'b1;
    @(posedge sys_clk);
    rcvBusy <= 1'b0;
    rcvByCore <= 1'b1;
    expectCount(0);
    setup(32'h565);
    issue(1, bem_pkg::KIND_LINE_RD, bem_pkg::SRC_L1D, 1'b1);
    issue(2, bem_pkg::KIND_LINE_RD, bem_pkg::SRC_L2PF, 1'b1);
    issue(3, bem_pkg::KIND_IFETCH, bem_pkg::SRC_IFU, 1'b1);
    issue(4, bem_pkg::KIND_OWN_RD, bem_pkg::SRC_L1D, 1'b1);
    for (int t = 1; t < 5; t++) done(t);
    quiet();
    expectCount(3);
    setup(32'h765);
    agent.drive(3, 2, 1);
    expectCount(2);
  endtask : t_rcvBurst
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, issueValid, doneValid} = 7'h00;
    {issueCacheable, ownDataDrive, lockUncached, lockSplit, lockWalkUc, rcvBusy} = 6'h00;
    {lockByCore, rcvByCore} = 2'h3;
    {awaddr, araddr, wdata, issueKind, issueSrc, issueTag, doneTag} = '0;
    badCount = 0;
    checks = 0;
    rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_pend();
    t_stall();
    t_data();
    t_lock();
    t_rcvBurst();
    print_verdict();
  end
  // Cuts a hang short well after the scenarios should have finished.
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
